// ===== clp_pkg.sv
// Constants, register map and carrier types of the charge-limit and thermal policy block
// Assumes one 200 MHz clock and a 32-bit AXI4-Lite register port
`default_nettype none
package clp_pkg;
  localparam int AXI_ADDR_W = 12;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_CONFIG = 10'h001;
  localparam logic [9:0] IDX_STATUS = 10'h003;
  localparam logic [9:0] IDX_SHORT = 10'h00b;
  localparam logic [9:0] IDX_VINMIN = 10'h016;
  localparam logic [9:0] IDX_FAST = 10'h018;
  localparam logic [9:0] IDX_PRECHG = 10'h019;
  localparam logic [9:0] IDX_ZONE = 10'h01c;
  localparam logic [9:0] IDX_INPCT = 10'h020;
  localparam logic [9:0] IDX_SETPT = 10'h021;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Field positions
  localparam int CFG_THERM_DIS_BIT = 0;
  localparam int ST_IIN_BIT = 0;
  localparam int ST_VIN_BIT = 1;
  localparam int ZN_DIS_BIT = 0;
  localparam int ZN_COLD_LSB = 1;
  localparam int ZN_WARM_I_BIT = 3;
  localparam int ZN_WARM_V_LSB = 4;
  // Values after reset
  localparam logic CFG_RST = 1'b0;
  localparam logic [1:0] SHORT_RST = 2'h0;
  localparam logic [1:0] PRECHG_RST = 2'h0;
  localparam logic [6:0] VINMIN_RST = 7'h00;
  localparam logic [6:0] FAST_RST = 7'h64;
  localparam logic [6:0] INPCT_RST = 7'h64;
  localparam logic [6:0] ZONE_RST = 7'h00;
  // Current and voltage figures
  localparam logic [3:0] DEAD_BATTERY_MA = 4'ha;
  localparam logic [6:0] PCT_NONE = 7'h00;
  localparam logic [6:0] PCT_MIN = 7'h01;
  localparam logic [6:0] PCT_QUARTER = 7'h19;
  localparam logic [6:0] PCT_HALF = 7'h32;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [19:0] PCT_DIV = 20'h00064;
  localparam logic [14:0] VIN_BASE_MV = 15'h0fa0;
  localparam logic [14:0] VIN_STEP_MV = 15'h0064;
  localparam logic [6:0] SHORT_PCT [4] = '{7'h01, 7'h02, 7'h04, 7'h08};
  localparam logic [6:0] PRECHG_PCT [4] = '{7'h05, 7'h0a, 7'h0f, 7'h14};
  localparam logic [9:0] WARM_DROP_MV [8] =
    '{10'h000, 10'h0c8, 10'h12c, 10'h190, 10'h1c2, 10'h1f4, 10'h258, 10'h2ee};

  typedef enum logic [1:0] {
    CLP_PH_DEAD = 2'h0, CLP_PH_SHORT = 2'h1, CLP_PH_PRE = 2'h2, CLP_PH_FAST = 2'h3
  } clp_phase_t;
  typedef enum {CLP_ZN_FROZEN, CLP_ZN_COOL, CLP_ZN_NORMAL, CLP_ZN_WARM, CLP_ZN_HOT} clp_zone_t;
  typedef enum logic [1:0] {CLP_RATE_STOP, CLP_RATE_HALF, CLP_RATE_FULL} clp_rate_t;

  typedef struct packed {
    logic out_of_window;
    logic above_60;
    logic above_45;
    logic below_10;
    logic below_0;
  } clp_temp_t;

  typedef struct packed {
    logic [3:0] fixed_ma;
    logic suspend;
    logic temp_fault;
    logic [6:0] fast_pct;
    logic [6:0] phase_pct;
    logic [9:0] vterm_drop_mv;
    clp_rate_t lowbatt_rate;
    clp_rate_t fast_rate;
  } clp_setpoint_t;
endpackage
`default_nettype wire

// ===== clp_policy.sv
// Charge current setpoints, input limit scaling and battery temperature zone policy
// Assumes analog comparators on the pins, an AXI4-Lite master and the clp_pkg package
// Behaviour
// - Dead battery requests fixed 10 mA
// - Short battery uses 1 to 8 percent
// - Precharge uses 5 to 20 percent
// - Input limit is hardware maximum times percent
// - Percent code kept; 0 acts 1, above 100 acts 100
// - Input current flag while current regulating
// - Current regulation halves both timer rates
// - Minimum input voltage is 4 V plus code tenths
// - Input voltage floor reduces charge current
// - Input voltage flag while voltage regulating
// - Voltage regulation halves both timer rates
// - Thermistor disable ignores temperature input entirely
// - Temperature outside window faults and stops charging
// - Below 0 C suspend charging and timers
// - Stopped timers hold counts and resume
// - Cool zone field scales fast current, timer
// - Warm voltage field lowers termination, halves timer
// - Warm current bit: half current or unchanged
// - Above 60 C suspend charging and timers
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
module clp_policy
  import clp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] charge_phase_pin,
  input wire logic charge_mode_pin,
  input wire logic reverse_supply_mode,
  input wire clp_temp_t thermistor_input,
  input wire logic input_current_at_limit,
  input wire logic input_voltage_at_min,
  input wire logic [12:0] hw_input_current_max,
  output clp_setpoint_t setpoint,
  output logic [12:0] effective_input_limit,
  output logic [14:0] min_input_voltage_mv,
  output logic charge_reduce,
  output logic input_current_reg_flag,
  output logic input_voltage_reg_flag
);
  localparam int SYNC_W = 24;

  // Checks wait one edge past release, when the synchronous reset has reached every flop
  logic asrt_live_reg;
  always_ff @(posedge aclk) begin
    asrt_live_reg <= aresetn;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !asrt_live_reg);

  // Every pin is asynchronous to aclk; the limit value is treated as quasi-static
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_sync;
  assign pin_raw = {hw_input_current_max, charge_phase_pin, charge_mode_pin,
                    reverse_supply_mode, input_current_at_limit, input_voltage_at_min,
                    thermistor_input};

  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    logic meta_reg;
    logic hold_reg;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_reg <= 1'b0;
        hold_reg <= 1'b0;
      end else begin
        meta_reg <= pin_raw[i];
        hold_reg <= meta_reg;
      end
    end
    assign pin_sync[i] = hold_reg;
  end

  clp_temp_t temp_s;
  logic vin_s;
  logic iin_s;
  logic rev_s;
  logic chg_s;
  clp_phase_t phase_s;
  logic [12:0] hwmax_s;
  assign temp_s = clp_temp_t'(pin_sync[4:0]);
  assign vin_s = pin_sync[5];
  assign iin_s = pin_sync[6];
  assign rev_s = pin_sync[7];
  assign chg_s = pin_sync[8];
  assign phase_s = clp_phase_t'(pin_sync[10:9]);
  assign hwmax_s = pin_sync[23:11];

  // Configuration registers
  logic therm_dis_reg;
  logic [1:0] short_sel_reg;
  logic [1:0] pre_sel_reg;
  logic [6:0] vinmin_reg;
  logic [6:0] fast_reg;
  logic [6:0] inpct_reg;
  logic [6:0] zone_cfg_reg;
  logic zoned_dis;
  logic [1:0] cold_sel;
  logic warm_i;
  logic [2:0] warm_v;
  assign zoned_dis = zone_cfg_reg[ZN_DIS_BIT];
  assign cold_sel = zone_cfg_reg[ZN_COLD_LSB +: 2];
  assign warm_i = zone_cfg_reg[ZN_WARM_I_BIT];
  assign warm_v = zone_cfg_reg[ZN_WARM_V_LSB +: 3];

  function automatic logic [6:0] clamp_pct(input logic [6:0] code);
    if (code == 7'h00) begin
      return PCT_MIN;
    end else if (code > PCT_MAX) begin
      return PCT_MAX;
    end
    return code;
  endfunction

  // AXI4-Lite write path: address and data may arrive in either order
  logic aw_held_reg;
  logic w_held_reg;
  logic [AXI_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic do_write;
  logic wr_hit;
  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready = !w_held_reg && !bvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  always_comb begin
    wr_hit = 1'b0;
    if (awaddr_reg[AXI_ADDR_W-1:2] == IDX_CONFIG || awaddr_reg[AXI_ADDR_W-1:2] == IDX_STATUS ||
        awaddr_reg[AXI_ADDR_W-1:2] == IDX_SHORT || awaddr_reg[AXI_ADDR_W-1:2] == IDX_VINMIN ||
        awaddr_reg[AXI_ADDR_W-1:2] == IDX_FAST || awaddr_reg[AXI_ADDR_W-1:2] == IDX_PRECHG ||
        awaddr_reg[AXI_ADDR_W-1:2] == IDX_ZONE || awaddr_reg[AXI_ADDR_W-1:2] == IDX_INPCT ||
        awaddr_reg[AXI_ADDR_W-1:2] == IDX_SETPT) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= wdata;
        wstrb0_reg <= wstrb[0];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Every field sits in byte lane 0; status and setpoint words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      therm_dis_reg <= CFG_RST;
      short_sel_reg <= SHORT_RST;
      pre_sel_reg <= PRECHG_RST;
      vinmin_reg <= VINMIN_RST;
      fast_reg <= FAST_RST;
      inpct_reg <= INPCT_RST;
      zone_cfg_reg <= ZONE_RST;
    end else if (do_write && wstrb0_reg) begin
      case (awaddr_reg[AXI_ADDR_W-1:2])
        IDX_CONFIG: therm_dis_reg <= wdata_reg[CFG_THERM_DIS_BIT];
        IDX_SHORT: short_sel_reg <= wdata_reg[1:0];
        IDX_PRECHG: pre_sel_reg <= wdata_reg[1:0];
        IDX_VINMIN: vinmin_reg <= wdata_reg[6:0];
        IDX_FAST: fast_reg <= wdata_reg[6:0];
        IDX_INPCT: inpct_reg <= wdata_reg[6:0];
        IDX_ZONE: zone_cfg_reg <= wdata_reg[6:0];
        default: begin
        end
      endcase
    end
  end

  // AXI4-Lite read path: one cycle from address to data
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rd_word;
  logic rd_hit;
  logic iin_flag_reg;
  logic vin_flag_reg;
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (araddr[AXI_ADDR_W-1:2])
      IDX_CONFIG: rd_word[CFG_THERM_DIS_BIT] = therm_dis_reg;
      IDX_STATUS: begin
        rd_word[ST_IIN_BIT] = iin_flag_reg;
        rd_word[ST_VIN_BIT] = vin_flag_reg;
      end
      IDX_SHORT: rd_word[1:0] = short_sel_reg;
      IDX_PRECHG: rd_word[1:0] = pre_sel_reg;
      IDX_VINMIN: rd_word[6:0] = vinmin_reg;
      IDX_FAST: rd_word[6:0] = fast_reg;
      IDX_INPCT: rd_word[6:0] = inpct_reg;
      IDX_ZONE: rd_word[6:0] = zone_cfg_reg;
      IDX_SETPT: rd_word = {setpoint.fast_rate, setpoint.lowbatt_rate, 1'b0,
                            setpoint.fixed_ma, setpoint.temp_fault, setpoint.suspend,
                            setpoint.phase_pct, 1'b0, setpoint.fast_pct, 6'h00};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Regulation loops only count while the charger is in charge mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iin_flag_reg <= 1'b0;
      vin_flag_reg <= 1'b0;
      charge_reduce <= 1'b0;
    end else begin
      iin_flag_reg <= iin_s && chg_s;
      vin_flag_reg <= vin_s && chg_s;
      charge_reduce <= (iin_s || vin_s) && chg_s;
    end
  end
  assign input_current_reg_flag = iin_flag_reg;
  assign input_voltage_reg_flag = vin_flag_reg;

  // Input limit and voltage floor, recomputed every cycle
  logic [19:0] inpct_prod;
  logic [19:0] inpct_quot;
  assign inpct_prod = 20'(hwmax_s) * 20'(clamp_pct(inpct_reg));
  assign inpct_quot = inpct_prod / PCT_DIV;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      effective_input_limit <= '0;
      min_input_voltage_mv <= VIN_BASE_MV;
    end else begin
      effective_input_limit <= inpct_quot[12:0];
      min_input_voltage_mv <= VIN_BASE_MV + 15'(vinmin_reg) * VIN_STEP_MV;
    end
  end

  // Temperature zone; fixed comparator points are the hardware's, not software's
  clp_zone_t zone_reg;
  logic temp_fault_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zone_reg <= CLP_ZN_NORMAL;
      temp_fault_reg <= 1'b0;
    end else begin
      temp_fault_reg <= !therm_dis_reg && temp_s.out_of_window && (chg_s || rev_s);
      if (therm_dis_reg || zoned_dis) begin
        zone_reg <= CLP_ZN_NORMAL;
      end else if (temp_s.below_0) begin
        zone_reg <= CLP_ZN_FROZEN;
      end else if (temp_s.above_60) begin
        zone_reg <= CLP_ZN_HOT;
      end else if (temp_s.below_10) begin
        zone_reg <= CLP_ZN_COOL;
      end else if (temp_s.above_45) begin
        zone_reg <= CLP_ZN_WARM;
      end else begin
        zone_reg <= CLP_ZN_NORMAL;
      end
    end
  end

  // Setpoint decode
  clp_setpoint_t sp;
  logic stop_all;
  logic fast_half;
  logic [6:0] zone_pct;
  always_comb begin
    stop_all = 1'b0;
    fast_half = 1'b0;
    zone_pct = PCT_MAX;
    sp = '0;
    case (zone_reg)
      CLP_ZN_FROZEN, CLP_ZN_HOT: stop_all = 1'b1;
      CLP_ZN_COOL: begin
        case (cold_sel)
          2'h0: stop_all = 1'b1;
          2'h1: begin
            zone_pct = PCT_QUARTER;
            fast_half = 1'b1;
          end
          2'h2: begin
            zone_pct = PCT_HALF;
            fast_half = 1'b1;
          end
          default: zone_pct = PCT_MAX;
        endcase
      end
      CLP_ZN_WARM: begin
        if (warm_v != 3'h0) begin
          sp.vterm_drop_mv = WARM_DROP_MV[warm_v];
          fast_half = 1'b1;
        end else if (!warm_i) begin
          zone_pct = PCT_HALF;
          fast_half = 1'b1;
        end
      end
      default: zone_pct = PCT_MAX;
    endcase
    sp.suspend = stop_all || temp_fault_reg;
    sp.temp_fault = temp_fault_reg;
    sp.fast_pct = clamp_pct(fast_reg);
    case (phase_s)
      CLP_PH_DEAD: begin
        sp.phase_pct = PCT_NONE;
        sp.fixed_ma = sp.suspend ? 4'h0 : DEAD_BATTERY_MA;
      end
      CLP_PH_SHORT: sp.phase_pct = SHORT_PCT[short_sel_reg];
      CLP_PH_PRE: sp.phase_pct = PRECHG_PCT[pre_sel_reg];
      default: sp.phase_pct = zone_pct;
    endcase
    // A stopped rate freezes the timer counts in place instead of clearing them
    if (sp.suspend) begin
      sp.fast_rate = CLP_RATE_STOP;
      sp.lowbatt_rate = CLP_RATE_STOP;
    end else begin
      sp.fast_rate = (fast_half || iin_flag_reg || vin_flag_reg) ? CLP_RATE_HALF
                                                                 : CLP_RATE_FULL;
      sp.lowbatt_rate = (iin_flag_reg || vin_flag_reg) ? CLP_RATE_HALF
                                                       : CLP_RATE_FULL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setpoint <= '0;
    end else begin
      setpoint <= sp;
    end
  end

  sequence s_iin_held;
    (input_current_at_limit && charge_mode_pin)[*4];
  endsequence
  sequence s_vin_held;
    (input_voltage_at_min && charge_mode_pin)[*4];
  endsequence

  AST_DEAD_FIXED: assert property ((phase_s == CLP_PH_DEAD && !sp.suspend) |=>
    setpoint.fixed_ma == DEAD_BATTERY_MA && setpoint.phase_pct == PCT_NONE)
    else $error("Dead battery current not fixed");
  AST_SHORT_PCT: assert property ((phase_s == CLP_PH_SHORT) |=>
    setpoint.phase_pct == SHORT_PCT[$past(short_sel_reg)])
    else $error("Short battery percentage wrong");
  AST_PRE_PCT: assert property ((phase_s == CLP_PH_PRE) |=>
    setpoint.phase_pct >= 7'h05 && setpoint.phase_pct <= 7'h14)
    else $error("Precharge percentage out of range");
  AST_INPCT_HIGH: assert property ((inpct_reg > PCT_MAX) |=>
    effective_input_limit == $past(hwmax_s))
    else $error("Input limit above full scale not clamped");
  AST_IIN_FLAG: assert property (s_iin_held |-> input_current_reg_flag)
    else $error("Input current flag missing");
  AST_VIN_FLAG: assert property (s_vin_held |-> input_voltage_reg_flag)
    else $error("Input voltage flag missing");
  AST_REG_HALF: assert property (((iin_flag_reg || vin_flag_reg) && !sp.suspend) |=>
    setpoint.fast_rate == CLP_RATE_HALF && setpoint.lowbatt_rate == CLP_RATE_HALF)
    else $error("Timers not halved during regulation");
  AST_THERM_IGNORED: assert property (therm_dis_reg |=>
    zone_reg == CLP_ZN_NORMAL && !temp_fault_reg)
    else $error("Thermistor not ignored");
  AST_EXTREME_STOP: assert property ((zone_reg == CLP_ZN_FROZEN || zone_reg == CLP_ZN_HOT)
    |=> setpoint.suspend && setpoint.fast_rate == CLP_RATE_STOP &&
    setpoint.lowbatt_rate == CLP_RATE_STOP)
    else $error("Extreme zone did not suspend");
  AST_COOL_QUARTER: assert property ((zone_reg == CLP_ZN_COOL && cold_sel == 2'h1 &&
    phase_s == CLP_PH_FAST && !temp_fault_reg) |=>
    setpoint.phase_pct == PCT_QUARTER && setpoint.fast_rate == CLP_RATE_HALF)
    else $error("Cool zone quarter current wrong");
endmodule
`default_nettype wire

// ===== clp_far_side.sv
// Behavioural analog side: battery temperature comparators and input loop sense
// Assumes the bench moves temperature, input current and input voltage after clock edges
`default_nettype none
module clp_far_side
  import clp_pkg::*;
#(
  parameter int COLD_LIM = -10,
  parameter int HOT_LIM = 65
)(
  input wire logic signed [7:0] temp_c,
  input wire logic [12:0] iin_ma,
  input wire logic [14:0] vin_mv,
  input wire logic [12:0] effective_input_limit,
  input wire logic [14:0] min_input_voltage_mv,
  output var clp_temp_t thermistor_input,
  output logic input_current_at_limit,
  output logic input_voltage_at_min
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ideal comparators; the design's synchronisers absorb their edges
  assign thermistor_input.below_0 = temp_c < 0;
  assign thermistor_input.below_10 = temp_c < 10;
  assign thermistor_input.above_45 = temp_c > 45;
  assign thermistor_input.above_60 = temp_c > 60;
  // Window limits sit outside the fixed zone edges, so both can be hit at once
  assign thermistor_input.out_of_window = temp_c < COLD_LIM || temp_c > HOT_LIM;
  // Loops engage when input current reaches the limit or the input sags to the floor
  assign input_current_at_limit = iin_ma >= effective_input_limit;
  assign input_voltage_at_min = vin_mv <= min_input_voltage_mv;
endmodule
`default_nettype wire

// ===== charge_limit_thermal_policy_test.sv
// Self-checking bench of the charge-limit and thermal policy block
// Assumes clp_far_side stands in for the analog side; the bench is the AXI4-Lite master
`default_nettype none
module charge_limit_thermal_policy_test import clp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, charge_reduce;
  logic input_current_reg_flag, input_voltage_reg_flag;
  logic input_current_at_limit, input_voltage_at_min;
  logic [1:0] bresp, rresp, rs;
  logic [1:0] charge_phase_pin = 2'h3;
  logic charge_mode_pin = 1'b1, reverse_supply_mode = 1'b0;
  clp_temp_t thermistor_input;
  clp_setpoint_t setpoint;
  logic [12:0] hw_input_current_max = 13'h0fa0, effective_input_limit, iin_ma = 13'h0000, hw;
  logic [14:0] min_input_voltage_mv, vin_mv = 15'h7fff;
  logic signed [7:0] temp_c = 8'sh19;
  logic [6:0] code, z;
  logic [2:0] vs;
  logic [21:0] e;
  int err_count = 0, tests_run = 0;
  int ra [5] = '{'h004, 'h060, 'h080, 'h058, 'h070};
  int rv [5] = '{0, 'h64, 'h64, 0, 0};
  int ts [5] = '{-5, 5, 25, 50, 70};
  logic [6:0] cin [4] = '{7'h00, 7'h64, 7'h65, 7'h7f};

  always #2.5 aclk = ~aclk;

  clp_policy i_clp_policy (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .charge_phase_pin(charge_phase_pin), .charge_mode_pin(charge_mode_pin),
    .reverse_supply_mode(reverse_supply_mode), .thermistor_input(thermistor_input),
    .input_current_at_limit(input_current_at_limit), .input_voltage_at_min(input_voltage_at_min),
    .hw_input_current_max(hw_input_current_max), .setpoint(setpoint),
    .effective_input_limit(effective_input_limit), .min_input_voltage_mv(min_input_voltage_mv),
    .charge_reduce(charge_reduce), .input_current_reg_flag(input_current_reg_flag),
    .input_voltage_reg_flag(input_voltage_reg_flag));

  clp_far_side i_clp_far_side (.temp_c(temp_c), .iin_ma(iin_ma), .vin_mv(vin_mv),
    .effective_input_limit(effective_input_limit), .min_input_voltage_mv(min_input_voltage_mv),
    .thermistor_input(thermistor_input), .input_current_at_limit(input_current_at_limit),
    .input_voltage_at_min(input_voltage_at_min));

  task automatic finish_test;
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready is judged at the falling edge, where it has settled, and acted on at the next rise
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tw, pa, pw;
    n = 0;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a[AXI_ADDR_W-1:0];
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw) && n < 50) begin
      @(negedge aclk);
      n++;
      pa = !ta && awready;
      pw = !tw && wready;
      @(posedge aclk);
      if (pa) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (pw) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    pa = 1'b0;
    while (!pa && n < 100) begin
      @(negedge aclk);
      n++;
      pa = bvalid;
      r = bresp;
    end
    @(posedge aclk);
    bready <= 1'b0;
    if (!pa) begin
      err_count++;
      finish_test;
    end
  endtask

  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic p;
    n = 0;
    p = 1'b0;
    @(posedge aclk);
    araddr <= a[AXI_ADDR_W-1:0];
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!p && n < 50) begin
      @(negedge aclk);
      n++;
      p = arready;
    end
    @(posedge aclk);
    arvalid <= 1'b0;
    p = 1'b0;
    while (!p && n < 100) begin
      @(negedge aclk);
      n++;
      p = rvalid;
      d = rdata;
      r = rresp;
    end
    @(posedge aclk);
    rready <= 1'b0;
    if (!p) begin
      err_count++;
      finish_test;
    end
  endtask

  // Pin effects need up to four edges through the synchronisers
  task automatic settle;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
  endtask

  function automatic logic [31:0] exp_lim(logic [12:0] h, logic [6:0] c);
    int p;
    p = (c == 0) ? 1 : ((c > 100) ? 100 : int'(c));
    return h * p / 100;
  endfunction

  // Packs suspend, phase percent, voltage drop, low battery rate and fast rate
  function automatic logic [21:0] exp_zone(int t, logic [6:0] zf);
    logic s;
    logic [6:0] p;
    logic [9:0] d;
    clp_rate_t l, f;
    s = 1'b0;
    p = 7'h64;
    d = 10'h000;
    l = CLP_RATE_FULL;
    f = CLP_RATE_FULL;
    if (t < 0 || t > 60 || (t < 10 && zf[2:1] == 2'h0)) begin
      s = 1'b1;
      l = CLP_RATE_STOP;
      f = CLP_RATE_STOP;
    end else if (t < 10) begin
      p = (zf[2:1] == 2'h1) ? 7'h19 : ((zf[2:1] == 2'h2) ? 7'h32 : 7'h64);
      f = (zf[2:1] == 2'h3) ? CLP_RATE_FULL : CLP_RATE_HALF;
    end else if (t > 45 && zf[6:4] != 3'h0) begin
      d = WARM_DROP_MV[zf[6:4]];
      f = CLP_RATE_HALF;
    end else if (t > 45 && !zf[3]) begin
      p = 7'h32;
      f = CLP_RATE_HALF;
    end
    return {s, p, d, l, f};
  endfunction

  initial begin
    void'($urandom(16));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd_reg(ra[i], rd, rs);
      chk(rd, rv[i]);
    end
    rd_reg(32'h0fc, rd, rs);
    chk({rs, rd[29:0]}, {RESP_SLVERR, 30'h0});
    wr(32'h0fc, 32'h1, rs);
    chk(rs, RESP_SLVERR);
    @(posedge aclk);
    wstrb <= 4'h0;
    wr(4 * IDX_FAST, 32'h0, rs);
    @(posedge aclk);
    wstrb <= 4'hf;
    rd_reg(4 * IDX_FAST, rd, rs);
    chk({rs, rd[29:0]}, {RESP_OKAY, 30'h64});
    wr(4 * IDX_STATUS, 32'h3, rs);
    rd_reg(4 * IDX_STATUS, rd, rs);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      code = (i < 4) ? cin[i] : 7'($urandom_range(0, 127));
      hw = 13'($urandom_range(100, 8191));
      @(posedge aclk);
      hw_input_current_max <= hw;
      wr(4 * IDX_INPCT, code, rs);
      chk(rs, RESP_OKAY);
      wr(4 * IDX_VINMIN, code, rs);
      wr(4 * IDX_FAST, code, rs);
      rd_reg(4 * IDX_INPCT, rd, rs);
      chk(rd, {25'h0, code});
      settle;
      chk(effective_input_limit, exp_lim(hw, code));
      chk(min_input_voltage_mv, 4000 + 100 * code);
      chk(setpoint.fast_pct, exp_lim(13'h0064, code));
      rd_reg(4 * IDX_SETPT, rd, rs);
      chk({rd[31:28], rd[12:6]}, {CLP_RATE_FULL, CLP_RATE_FULL, 7'(exp_lim(13'h0064, code))});
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      iin_ma <= i[0] ? effective_input_limit : 13'h0000;
      vin_mv <= i[1] ? min_input_voltage_mv : 15'h7fff;
      settle;
      chk(input_current_reg_flag, i[0]);
      chk(input_voltage_reg_flag, i[1]);
      chk(charge_reduce, i[0] | i[1]);
      chk(setpoint.fast_rate, (i > 0) ? CLP_RATE_HALF : CLP_RATE_FULL);
      chk(setpoint.lowbatt_rate, (i > 0) ? CLP_RATE_HALF : CLP_RATE_FULL);
      rd_reg(4 * IDX_STATUS, rd, rs);
      chk(rd, i);
    end
    @(posedge aclk);
    charge_mode_pin <= 1'b0;
    settle;
    chk(charge_reduce, 1'b0);
    @(posedge aclk);
    charge_mode_pin <= 1'b1;
    iin_ma <= 13'h0000;
    vin_mv <= 15'h7fff;
    for (int s = 0; s < 4; s++) begin
      wr(4 * IDX_SHORT, s, rs);
      wr(4 * IDX_PRECHG, s, rs);
      for (int p = 0; p < 3; p++) begin
        @(posedge aclk);
        charge_phase_pin <= 2'(p);
        settle;
        case (p)
          0: chk(setpoint.fixed_ma, 10);
          1: chk(setpoint.phase_pct, SHORT_PCT[s]);
          default: chk(setpoint.phase_pct, PRECHG_PCT[s]);
        endcase
      end
    end
    @(posedge aclk);
    charge_phase_pin <= 2'h3;
    for (int i = 0; i < 40; i++) begin
      vs = (i % 3 == 0) ? 3'h0 : 3'($urandom_range(1, 7));
      z = {vs, 1'(i >= 20), 2'(i / 5), 1'b0};
      @(posedge aclk);
      temp_c <= 8'(ts[i % 5]);
      wr(4 * IDX_ZONE, z, rs);
      settle;
      e = exp_zone(ts[i % 5], z);
      chk(setpoint.suspend, e[21]);
      if (!e[21]) begin
        chk({setpoint.phase_pct, setpoint.vterm_drop_mv}, e[20:4]);
      end
      chk({setpoint.lowbatt_rate, setpoint.fast_rate}, e[3:0]);
    end
    wr(4 * IDX_CONFIG, 32'h1, rs);
    @(posedge aclk);
    temp_c <= -8'sd20;
    settle;
    chk({setpoint.suspend, setpoint.temp_fault, setpoint.fast_rate}, CLP_RATE_FULL);
    wr(4 * IDX_CONFIG, 32'h0, rs);
    wr(4 * IDX_ZONE, 32'h1, rs);
    @(posedge aclk);
    temp_c <= 8'sd70;
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      charge_mode_pin <= (i == 0);
      reverse_supply_mode <= (i == 2);
      settle;
      chk(setpoint.temp_fault, i != 1);
    end
    finish_test;
  end
endmodule
`default_nettype wire
